// ==== src/iocn_map.svh ====
`ifndef IOCN_MAP_SVH
`define IOCN_MAP_SVH
// Register byte offsets and word indices
`define IOCN_GLB_CTRL   8'h00
`define IOCN_STATUS     8'h04
`define IOCN_LINE_WORD  4
`define IOCN_CELL_WORD  16
// Network sizes
`define IOCN_LINES      12
`define IOCN_GLOBALS    4
`define IOCN_DED_PINS   6
`define IOCN_CLK_PINS   2
`define IOCN_CE_SLOTS   6
`define IOCN_ADDR_W     8
`define IOCN_CFG_W      21
`define IOCN_SRC_W      5
// Status field positions
`define IOCN_ST_LINE    0
`define IOCN_ST_GLB     12
`define IOCN_ST_CELL    16
// Reset values and answers
`define IOCN_GLB_RST    4'h0
`define IOCN_RESP_OKAY  2'b00
`define IOCN_RESP_SLV   2'b10
`endif

// ==== src/iocn_pkg.sv ====
`include "iocn_map.svh"
package iocn_pkg;
	typedef enum logic [1:0] {SRC_NONE, SRC_PIN, SRC_ROW, SRC_COL} iocn_src_t;
	typedef enum logic [1:0] {MODE_OFF, MODE_IN, MODE_OUT, MODE_BIDIR}
		iocn_mode_t;
	typedef enum logic [1:0] {CK_BUS0, CK_BUS1, CK_PIN0, CK_PIN1}
		iocn_clk_sel_t;

	typedef struct packed {
		logic [2:0] idx;
		iocn_src_t  kind;
	} iocn_line_src_t;

	typedef struct packed {
		logic [3:0]    out_sel;
		logic          reg_out;
		logic          reg_in;
		logic          oe_local;
		logic [2:0]    oe_slot;
		logic          ce_en;
		logic          ce_local;
		logic [2:0]    ce_slot;
		logic          clr_sel;
		logic          clr_en;
		iocn_clk_sel_t clk_sel;
		iocn_mode_t    mode;
	} iocn_cell_cfg_t;

	typedef struct packed {
		logic clk_lvl;
		logic clr;
		logic ce;
		logic oe;
	} iocn_cell_ctl_t;

	typedef struct packed {
		logic clk_prev;
		logic q;
		logic pad;
		logic oe_b;
		logic din;
	} iocn_cell_st_t;

	typedef struct packed {
		logic                     awvalid;
		logic [`IOCN_ADDR_W-1:0]  awaddr;
		logic                     wvalid;
		logic [31:0]              wdata;
		logic [3:0]               wstrb;
		logic                     bready;
		logic                     arvalid;
		logic [`IOCN_ADDR_W-1:0]  araddr;
		logic                     rready;
	} iocn_axi_m2s_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} iocn_axi_s2m_t;
endpackage : iocn_pkg

// ==== src/iocn_io_cell.sv ====
`timescale 1ns/1ps
module iocn_io_cell (
	input  wire logic                    clk_in,
	input  wire logic                    rst_n_in,
	input  wire logic                    chip_rst_in,
	input  wire logic                    chip_oe_b_in,
	input  wire iocn_pkg::iocn_cell_cfg_t cfg_in,
	input  wire iocn_pkg::iocn_cell_ctl_t ctl_in,
	input  wire logic                    pad_in,
	input  wire logic                    out_data_in,
	output logic                         pad_out,
	output logic                         pad_oe_b_out,
	output logic                         din_out,
	output logic                         q_out
);
	import iocn_pkg::*;

	iocn_cell_st_t st_r;
	iocn_cell_st_t st_nxt;
	logic          tick;
	logic          ce;
	logic          is_in;
	logic          is_out;
	logic          drive;

	////////////////////////////////////////////////////////////////////////
	// Register clock edge, enables, direction
	always_comb
	begin
		tick   = ctl_in.clk_lvl & ~st_r.clk_prev;
		ce     = cfg_in.ce_en ? ctl_in.ce : 1'b1;
		is_in  = (cfg_in.mode == MODE_IN) || (cfg_in.mode == MODE_BIDIR);
		is_out = (cfg_in.mode == MODE_OUT) || (cfg_in.mode == MODE_BIDIR);
		drive  = (cfg_in.mode == MODE_OUT) ||
			((cfg_in.mode == MODE_BIDIR) && ctl_in.oe);
	end

	// Next state of the cell register and pad drivers
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.clk_prev = ctl_in.clk_lvl;
		if (chip_rst_in)
			st_nxt.q = 1'b0;
		else if (ctl_in.clr)
			st_nxt.q = 1'b0;
		else if (tick && ce)
		begin
			if (cfg_in.reg_in && is_in)
				st_nxt.q = pad_in;
			else if (cfg_in.reg_out && is_out)
				st_nxt.q = out_data_in;
		end
		st_nxt.pad  = cfg_in.reg_out ? st_r.q : out_data_in;
		st_nxt.oe_b = ~(is_out && drive && chip_oe_b_in);
		st_nxt.din  = is_in ? (cfg_in.reg_in ? st_r.q : pad_in) : 1'b0;
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_r <= '{clk_prev: 1'b0, q: 1'b0, pad: 1'b0, oe_b: 1'b1,
				din: 1'b0};
		else
			st_r <= st_nxt;
	end

	assign pad_out      = st_r.pad;
	assign pad_oe_b_out = st_r.oe_b;
	assign din_out      = st_r.din;
	assign q_out        = st_r.q;
endmodule : iocn_io_cell

// ==== src/iocn_top.sv ====
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "iocn_map.svh"
// Summary of operation
// - Twelve shared control lines feed every cell's clock, clear, enables.
// - Lines give up to eight OE, six CE, two clocks, two clears.
// - Each cell picks its own clock, clear, CE and OE line.
// - Cell CE and OE may come from a dedicated logic cell instead.
// - Cell clock may also come from either of two clock pins.
// - Line driven by a dedicated pin, row group cell, or column route.
// - Chip-wide reset low clears every cell register, above all else.
// - Each line has a fixed set of roles it can serve.
// - Four lines can drive the four low-skew global lines.
// - Chip-wide output enable low floats every pin.
// - Input cell drives two row channels seen across the row.
// - Output cell takes data from a row channel multiplexer.
// - Row multiplexer reaches a fixed subset of row channels.
// - Column-end input cell drives two column channels.
// - Column cells each pick output data by own column multiplexer.
// - Each column cell reaches a different group of channels.
// - Cell has a two-way buffer and one in-or-out register.
// - Six dedicated pins usable as control sources or data.
module iocn_top #(
	parameter int N_ROW_CELLS = 4,
	parameter int N_COL_CELLS = 2,
	parameter int ROW_W       = 16,
	parameter int ROW_M       = 2,
	parameter int COL_W       = 8,
	parameter int COL_M       = 4,
	parameter int ROWS        = 3,
	parameter int GROUPS      = 4,
	parameter logic [11:0][3:0] LINE_ROW = {4'h2, 4'h2, 4'h1, 4'h1,
		4'h0, 4'h0, 4'h2, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0}
) (
	input  wire logic                        REF_CLK_IN,
	input  wire logic                        RST_B_IN,
	input  wire logic                        CHIP_RST_B_IN,
	input  wire logic                        CHIP_OE_B_IN,
	input  wire logic [`IOCN_DED_PINS-1:0]   DED_PIN_IN,
	input  wire logic [`IOCN_CLK_PINS-1:0]   CLK_PIN_IN,
	input  wire logic [ROWS*GROUPS-1:0]      FIRST_LC_IN,
	input  wire logic [ROW_W-1:0]            ROW_CH_IN,
	input  wire logic [COL_W-1:0]            COL_CH_IN,
	input  wire logic [N_ROW_CELLS+N_COL_CELLS-1:0] LC_CE_IN,
	input  wire logic [N_ROW_CELLS+N_COL_CELLS-1:0] LC_OE_IN,
	input  wire logic [N_ROW_CELLS+N_COL_CELLS-1:0] PAD_IN,
	output logic [N_ROW_CELLS+N_COL_CELLS-1:0]      PAD_OUT,
	output logic [N_ROW_CELLS+N_COL_CELLS-1:0]      PAD_OE_B_OUT,
	output logic [ROW_W-1:0]                 ROW_DRV_OUT,
	output logic [COL_W-1:0]                 COL_DRV_OUT,
	output logic [`IOCN_GLOBALS-1:0]         GLOBAL_OUT,
	input  wire iocn_pkg::iocn_axi_m2s_t     S_AXI_IN,
	output iocn_pkg::iocn_axi_s2m_t          S_AXI_OUT
);
	import iocn_pkg::*;

	localparam int NC       = N_ROW_CELLS + N_COL_CELLS;
	localparam int ROW_STEP = ROW_W / ROW_M;
	localparam int NL       = `IOCN_LINES;
	localparam int ND       = `IOCN_DED_PINS;

	typedef struct packed {
		logic [ND-1:0]                 ded_s1;
		logic [ND-1:0]                 ded_s2;
		logic [`IOCN_CLK_PINS-1:0]     ck_s1;
		logic [`IOCN_CLK_PINS-1:0]     ck_s2;
		logic                          rst_s1;
		logic                          rst_s2;
		logic                          oe_s1;
		logic                          oe_s2;
		logic [NC-1:0]                 pad_s1;
		logic [NC-1:0]                 pad_s2;
		logic [NL-1:0]                 lines;
		logic [`IOCN_GLOBALS-1:0]      globals;
		logic [`IOCN_GLOBALS-1:0]      glb_ctrl;
		iocn_line_src_t [NL-1:0]       line_src;
		iocn_cell_cfg_t [NC-1:0]       cell_cfg;
		logic                          aw_full;
		logic [`IOCN_ADDR_W-1:0]       aw_addr;
		logic                          w_full;
		logic [31:0]                   w_data;
		logic [3:0]                    w_strb;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          rvalid;
		logic [31:0]                   rdata;
		logic [1:0]                    rresp;
	} iocn_top_st_t;

	iocn_top_st_t                st_r;
	iocn_top_st_t                st_nxt;
	logic [1:0]                  rst_sync_r;
	logic                        rst_n;
	logic [NL-1:0]               line_val;
	iocn_cell_ctl_t [NC-1:0]     ctl;
	logic [NC-1:0]               cell_data;
	logic [NC-1:0]               cell_din;
	logic [NC-1:0]               cell_q;

	////////////////////////////////////////////////////////////////////////
	// Line index decoding shared by several selectors

	// Level of a line, low for an invalid index
	function automatic logic line_pick(input logic [NL-1:0] l, input int i);
		return (i >= 0 && i < NL) ? l[i] : 1'b0;
	endfunction : line_pick

	// Output enable slot to line
	function automatic int oe_line(input logic [2:0] s);
		case (s)
			3'h6:    return 7;
			3'h7:    return 9;
			default: return int'(s);
		endcase
	endfunction : oe_line

	// Clock enable slot to line
	function automatic int ce_line(input logic [2:0] s);
		return (s < 3'h6) ? 6 + int'(s) : -1;
	endfunction : ce_line

	// Global line to the control line behind it
	function automatic int glb_line(input int g);
		case (g)
			0:       return 6;
			1:       return 7;
			2:       return 9;
			default: return 11;
		endcase
	endfunction : glb_line

	// Byte-lane write merge
	function automatic logic [31:0] merge32(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[8*b +: 8] = n[8*b +: 8];
		return r;
	endfunction : merge32

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	////////////////////////////////////////////////////////////////////////
	// Control line sources
	always_comb
	begin
		for (int j = 0; j < NL; j++)
		begin
			case (st_r.line_src[j].kind)
				SRC_PIN:
					line_val[j] = (int'(st_r.line_src[j].idx) < ND) ?
						st_r.ded_s2[st_r.line_src[j].idx] : 1'b0;
				SRC_ROW:
					line_val[j] = (int'(st_r.line_src[j].idx) < GROUPS &&
						int'(LINE_ROW[j]) < ROWS) ?
						FIRST_LC_IN[int'(LINE_ROW[j]) * GROUPS +
						int'(st_r.line_src[j].idx)] : 1'b0;
				SRC_COL:
					line_val[j] = (int'(st_r.line_src[j].idx) < COL_W) ?
						COL_CH_IN[st_r.line_src[j].idx] : 1'b0;
				default:
					line_val[j] = 1'b0;
			endcase
		end
	end

	// Per-cell control selection from the shared lines
	always_comb
	begin
		for (int k = 0; k < NC; k++)
		begin
			case (st_r.cell_cfg[k].clk_sel)
				CK_BUS0: ctl[k].clk_lvl = st_r.lines[6];
				CK_BUS1: ctl[k].clk_lvl = st_r.lines[11];
				CK_PIN0: ctl[k].clk_lvl = st_r.ck_s2[0];
				default: ctl[k].clk_lvl = st_r.ck_s2[1];
			endcase
			ctl[k].clr = st_r.cell_cfg[k].clr_en &&
				(st_r.cell_cfg[k].clr_sel ? st_r.lines[10] :
				st_r.lines[8]);
			ctl[k].ce = st_r.cell_cfg[k].ce_local ? LC_CE_IN[k] :
				line_pick(st_r.lines,
				ce_line(st_r.cell_cfg[k].ce_slot));
			ctl[k].oe = st_r.cell_cfg[k].oe_local ? LC_OE_IN[k] :
				line_pick(st_r.lines,
				oe_line(st_r.cell_cfg[k].oe_slot));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// I/O cells and their channel multiplexers
	for (genvar k = 0; k < NC; k++)
	begin : g_cell
		if (k < N_ROW_CELLS)
		begin : g_row
			// Fixed subset: every ROW_STEP-th channel from k
			assign cell_data[k] =
				(int'(st_r.cell_cfg[k].out_sel) < ROW_M) ?
				ROW_CH_IN[(k + int'(st_r.cell_cfg[k].out_sel) * ROW_STEP)
				% ROW_W] : 1'b0;
			assign ROW_DRV_OUT[2*k +: 2] = {2{cell_din[k]}};
		end
		else
		begin : g_col
			localparam int C = k - N_ROW_CELLS;
			// Window of COL_M channels starting at C, unique per cell
			assign cell_data[k] =
				(int'(st_r.cell_cfg[k].out_sel) < COL_M) ?
				COL_CH_IN[(C + int'(st_r.cell_cfg[k].out_sel)) % COL_W] :
				1'b0;
			assign COL_DRV_OUT[2*C +: 2] = {2{cell_din[k]}};
		end

		iocn_io_cell iocn_io_cell_inst (
			.clk_in       (REF_CLK_IN),
			.rst_n_in     (rst_n),
			.chip_rst_in  (~st_r.rst_s2),
			.chip_oe_b_in (st_r.oe_s2),
			.cfg_in       (st_r.cell_cfg[k]),
			.ctl_in       (ctl[k]),
			.pad_in       (st_r.pad_s2[k]),
			.out_data_in  (cell_data[k]),
			.pad_out      (PAD_OUT[k]),
			.pad_oe_b_out (PAD_OE_B_OUT[k]),
			.din_out      (cell_din[k]),
			.q_out        (cell_q[k])
		);
	end

	// Channels with no cell behind them stay low
	if (ROW_W > 2*N_ROW_CELLS)
	begin : g_row_pad
		assign ROW_DRV_OUT[ROW_W-1:2*N_ROW_CELLS] = '0;
	end
	if (COL_W > 2*N_COL_CELLS)
	begin : g_col_pad
		assign COL_DRV_OUT[COL_W-1:2*N_COL_CELLS] = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Bus handshakes
	assign S_AXI_OUT.awready = !st_r.aw_full && !st_r.bvalid;
	assign S_AXI_OUT.wready  = !st_r.w_full && !st_r.bvalid;
	assign S_AXI_OUT.bvalid  = st_r.bvalid;
	assign S_AXI_OUT.bresp   = st_r.bresp;
	assign S_AXI_OUT.arready = !st_r.rvalid;
	assign S_AXI_OUT.rvalid  = st_r.rvalid;
	assign S_AXI_OUT.rdata   = st_r.rdata;
	assign S_AXI_OUT.rresp   = st_r.rresp;
	assign GLOBAL_OUT        = st_r.globals;

	// Next state: synchronisers, lines, globals, registers
	always_comb
	begin
		int          wa;
		int          ra;
		logic [31:0] m;
		wa = int'(st_r.aw_addr[`IOCN_ADDR_W-1:2]);
		ra = int'(S_AXI_IN.araddr[`IOCN_ADDR_W-1:2]);
		m  = 32'h0;
		st_nxt = st_r;
		st_nxt.ded_s1 = DED_PIN_IN;
		st_nxt.ded_s2 = st_r.ded_s1;
		st_nxt.ck_s1  = CLK_PIN_IN;
		st_nxt.ck_s2  = st_r.ck_s1;
		st_nxt.rst_s1 = CHIP_RST_B_IN;
		st_nxt.rst_s2 = st_r.rst_s1;
		st_nxt.oe_s1  = CHIP_OE_B_IN;
		st_nxt.oe_s2  = st_r.oe_s1;
		st_nxt.pad_s1 = PAD_IN;
		st_nxt.pad_s2 = st_r.pad_s1;
		st_nxt.lines  = line_val;
		for (int g = 0; g < `IOCN_GLOBALS; g++)
			st_nxt.globals[g] = st_r.glb_ctrl[g] ?
				line_pick(st_r.lines, glb_line(g)) :
				st_r.ded_s2[g];

		// Write response retires
		if (st_r.bvalid && S_AXI_IN.bready)
			st_nxt.bvalid = 1'b0;
		// Write performed once address and data are both held
		if (st_r.aw_full && st_r.w_full && !st_r.bvalid)
		begin
			st_nxt.aw_full = 1'b0;
			st_nxt.w_full  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = `IOCN_RESP_OKAY;
			if (wa == 0)
			begin
				m = merge32({28'h0, st_r.glb_ctrl}, st_r.w_data,
					st_r.w_strb);
				st_nxt.glb_ctrl = m[`IOCN_GLOBALS-1:0];
			end
			else if (wa >= `IOCN_LINE_WORD &&
				wa < `IOCN_LINE_WORD + NL)
			begin
				m = merge32({27'h0, st_r.line_src[wa-`IOCN_LINE_WORD]},
					st_r.w_data, st_r.w_strb);
				st_nxt.line_src[wa-`IOCN_LINE_WORD] =
					m[`IOCN_SRC_W-1:0];
			end
			else if (wa >= `IOCN_CELL_WORD &&
				wa < `IOCN_CELL_WORD + NC)
			begin
				m = merge32({11'h0, st_r.cell_cfg[wa-`IOCN_CELL_WORD]},
					st_r.w_data, st_r.w_strb);
				st_nxt.cell_cfg[wa-`IOCN_CELL_WORD] =
					m[`IOCN_CFG_W-1:0];
			end
			else if (wa != 1)
				st_nxt.bresp = `IOCN_RESP_SLV;
		end
		// Address and data captured in either order
		if (S_AXI_IN.awvalid && !st_r.aw_full && !st_r.bvalid)
		begin
			st_nxt.aw_full = 1'b1;
			st_nxt.aw_addr = S_AXI_IN.awaddr;
		end
		if (S_AXI_IN.wvalid && !st_r.w_full && !st_r.bvalid)
		begin
			st_nxt.w_full = 1'b1;
			st_nxt.w_data = S_AXI_IN.wdata;
			st_nxt.w_strb = S_AXI_IN.wstrb;
		end

		// Read channel
		if (st_r.rvalid && S_AXI_IN.rready)
			st_nxt.rvalid = 1'b0;
		if (S_AXI_IN.arvalid && !st_r.rvalid)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = `IOCN_RESP_OKAY;
			st_nxt.rdata  = 32'h0;
			if (ra == 0)
				st_nxt.rdata[`IOCN_GLOBALS-1:0] = st_r.glb_ctrl;
			else if (ra == 1)
			begin
				st_nxt.rdata[`IOCN_ST_LINE +: NL] = st_r.lines;
				st_nxt.rdata[`IOCN_ST_GLB +: `IOCN_GLOBALS] =
					st_r.globals;
				st_nxt.rdata[`IOCN_ST_CELL +: NC] = cell_q;
			end
			else if (ra >= `IOCN_LINE_WORD &&
				ra < `IOCN_LINE_WORD + NL)
				st_nxt.rdata[`IOCN_SRC_W-1:0] =
					st_r.line_src[ra-`IOCN_LINE_WORD];
			else if (ra >= `IOCN_CELL_WORD &&
				ra < `IOCN_CELL_WORD + NC)
				st_nxt.rdata[`IOCN_CFG_W-1:0] =
					st_r.cell_cfg[ra-`IOCN_CELL_WORD];
			else
				st_nxt.rresp = `IOCN_RESP_SLV;
		end
	end

	// State register
	always_ff @(posedge REF_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r          <= '0;
			st_r.glb_ctrl <= `IOCN_GLB_RST;
		end
		else
			st_r <= st_nxt;
	end
endmodule : iocn_top

// ==== verif/iocn_top_asserts.sv ====
`timescale 1ns/1ps
module iocn_top_asserts #(
	parameter int N_ROW_CELLS = 4,
	parameter int N_COL_CELLS = 2,
	parameter int ROW_W       = 16,
	parameter int COL_W       = 8
) (
	input wire logic                                 REF_CLK_IN,
	input wire logic                                 RST_B_IN,
	input wire logic                                 CHIP_OE_B_IN,
	input wire logic [N_ROW_CELLS+N_COL_CELLS-1:0]   PAD_OE_B_OUT,
	input wire logic [ROW_W-1:0]                     ROW_DRV_OUT,
	input wire logic [COL_W-1:0]                     COL_DRV_OUT,
	input wire iocn_pkg::iocn_axi_m2s_t              S_AXI_IN,
	input wire iocn_pkg::iocn_axi_s2m_t              S_AXI_OUT
);
	import iocn_pkg::*;
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_B_IN);

	////////////////////////////////////////////////////////////////////////
	// Bus acceptance steps
	sequence s_wr_take;
		S_AXI_IN.awvalid && S_AXI_OUT.awready && S_AXI_IN.wvalid &&
			S_AXI_OUT.wready;
	endsequence
	sequence s_rd_take;
		S_AXI_IN.arvalid && S_AXI_OUT.arready;
	endsequence

	////////////////////////////////////////////////////////////////////////
	// Register bus answers and holding
	a_wr_answer: assert property (s_wr_take |-> ##[1:2] S_AXI_OUT.bvalid)
		else $error("write response late");
	a_rd_answer: assert property (s_rd_take |=> S_AXI_OUT.rvalid)
		else $error("read response late");
	a_b_stands: assert property (S_AXI_OUT.bvalid && !S_AXI_IN.bready
		|=> S_AXI_OUT.bvalid && $stable(S_AXI_OUT.bresp))
		else $error("write response dropped");
	a_r_stands: assert property (S_AXI_OUT.rvalid && !S_AXI_IN.rready
		|=> S_AXI_OUT.rvalid && $stable(S_AXI_OUT.rdata))
		else $error("read data dropped");
	a_rd_refuse: assert property (S_AXI_OUT.rvalid |-> !S_AXI_OUT.arready)
		else $error("read taken while busy");
	a_wr_refuse: assert property (S_AXI_OUT.bvalid
		|-> !S_AXI_OUT.awready && !S_AXI_OUT.wready)
		else $error("write taken while busy");

	////////////////////////////////////////////////////////////////////////
	// Pad float and channel drive spans
	a_oe_float: assert property ((!CHIP_OE_B_IN) [*4] |-> &PAD_OE_B_OUT)
		else $error("pads driven while chip output enable low");
	a_row_pair: assert property (ROW_DRV_OUT[0] == ROW_DRV_OUT[1])
		else $error("row channel pair differs");
	a_row_span: assert property ((ROW_DRV_OUT >> (2*N_ROW_CELLS)) == '0)
		else $error("row channel driven beyond cell pairs");
	a_col_span: assert property ((COL_DRV_OUT >> (2*N_COL_CELLS)) == '0)
		else $error("column channel driven beyond cell pairs");
endmodule : iocn_top_asserts

bind iocn_top iocn_top_asserts #(
	.N_ROW_CELLS(N_ROW_CELLS),
	.N_COL_CELLS(N_COL_CELLS),
	.ROW_W(ROW_W),
	.COL_W(COL_W)
) iocn_top_asserts_inst (
	.REF_CLK_IN(REF_CLK_IN),
	.RST_B_IN(RST_B_IN),
	.CHIP_OE_B_IN(CHIP_OE_B_IN),
	.PAD_OE_B_OUT(PAD_OE_B_OUT),
	.ROW_DRV_OUT(ROW_DRV_OUT),
	.COL_DRV_OUT(COL_DRV_OUT),
	.S_AXI_IN(S_AXI_IN),
	.S_AXI_OUT(S_AXI_OUT)
);

// ==== verif/iocn_far_model.sv ====
`timescale 1ns/1ps
module iocn_far_model (
	input  wire logic [3:0]  tie_in,
	input  wire logic [5:0]  ded_in,
	input  wire logic [11:0] lc_in,
	output logic [5:0]       ded_out,
	output logic [11:0]      lc_out
);
	// Pins behind internally driven globals held low, never floating
	assign ded_out = ded_in & ~{2'h0, tie_in};
	// First cell of each group drives its level straight on
	assign lc_out = lc_in;
endmodule : iocn_far_model

// ==== verif/iocn_top_tb.sv ====
`timescale 1ns/1ps
`include "iocn_map.svh"
module iocn_top_tb;
	import iocn_pkg::*;
	typedef struct {
		logic [7:0]  a;
		logic [31:0] d;
		logic [3:0]  s;
		logic [31:0] q;
		logic [1:0]  r;
	} iocn_row_t;
	logic clk, rst_b, chip_rst_b, chip_oe_b;
	logic [5:0] ded, ded_w, pad_in, ce, oe, pad_out, pad_oe_b;
	logic [11:0] lc, lc_w;
	logic [15:0] row, row_drv;
	logic [7:0] col, col_drv;
	logic [3:0] tie, glb, v;
	logic [1:0] clkp, rr;
	logic [31:0] rq;
	iocn_axi_m2s_t m;
	iocn_axi_s2m_t so;
	int error_cnt, comparisons;
	iocn_row_t rows [8];

	////////////////////////////////////////////////////////////////////////
	// Design and logic side
	iocn_top iocn_top_inst (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
		.CHIP_RST_B_IN(chip_rst_b), .CHIP_OE_B_IN(chip_oe_b),
		.DED_PIN_IN(ded_w), .CLK_PIN_IN(clkp), .FIRST_LC_IN(lc_w),
		.ROW_CH_IN(row), .COL_CH_IN(col), .LC_CE_IN(ce), .LC_OE_IN(oe),
		.PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE_B_OUT(pad_oe_b),
		.ROW_DRV_OUT(row_drv), .COL_DRV_OUT(col_drv), .GLOBAL_OUT(glb),
		.S_AXI_IN(m), .S_AXI_OUT(so));
	iocn_far_model iocn_far_model_inst (.tie_in(tie), .ded_in(ded),
		.lc_in(lc), .ded_out(ded_w), .lc_out(lc_w));

	////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic close_out;
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// One bus transfer, held until its answer is sampled
	// Response ready is raised lag+1 edges after the request, then held until answered
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, input int lag = 0);
		int n;
		@(posedge clk);
		if (we)
		begin
			m.awvalid <= 1'b1; m.awaddr <= a; m.wvalid <= 1'b1;
			m.wdata <= d; m.wstrb <= s;
		end
		else
		begin
			m.arvalid <= 1'b1; m.araddr <= a;
		end
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (m.awvalid && so.awready) m.awvalid <= 1'b0;
			if (m.wvalid && so.wready) m.wvalid <= 1'b0;
			if (m.arvalid && so.arready) m.arvalid <= 1'b0;
			if ((m.bready && so.bvalid) || (m.rready && so.rvalid)) break;
			if (n == lag)
			begin
				m.bready <= we;
				m.rready <= !we;
			end
		end
		rq = so.rdata;
		rr = we ? so.bresp : so.rresp;
		m.bready <= 1'b0;
		m.rready <= 1'b0;
		if (n == 50)
		begin
			error_cnt++;
			close_out();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
		chk("bresp", rr, `IOCN_RESP_OKAY);
	endtask : wr
	task automatic rd(input logic [7:0] a, input int lag = 0);
		bus(1'b0, a, 32'h0, 4'h0, lag);
	endtask : rd
	task automatic pulse;
		clkp <= 2'h1;
		tick(4);
		clkp <= 2'h0;
		tick(4);
	endtask : pulse

	////////////////////////////////////////////////////////////////////////
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst_b = 1'b0; chip_rst_b = 1'b1; chip_oe_b = 1'b1; m = '0;
		ded = '0; lc = '0; row = '0; col = '0; ce = '0; oe = '0;
		pad_in = '0; tie = '0; clkp = '0;
		error_cnt = 0; comparisons = 0;
		rows = '{'{8'h04, 32'hffff_ffff, 4'hf, 32'h0, `IOCN_RESP_OKAY},
			'{8'h00, 32'hffff_ffff, 4'hf, 32'hf, `IOCN_RESP_OKAY},
			'{8'h00, 32'h0, 4'hf, 32'h0, `IOCN_RESP_OKAY},
			'{8'h10, 32'hffff_ffff, 4'hf, 32'h1f, `IOCN_RESP_OKAY},
			'{8'h3c, 32'hffff_ffff, 4'hf, 32'h1f, `IOCN_RESP_OKAY},
			'{8'h54, 32'h001f_ffff, 4'h4, 32'h001f_0000, `IOCN_RESP_OKAY},
			'{8'h40, 32'h0012_3456, 4'h3, 32'h3456, `IOCN_RESP_OKAY},
			'{8'h58, 32'hff, 4'hf, 32'h0, `IOCN_RESP_SLV}};
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		tick(3);
		// Register rows: write, read back, answer codes
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].a, rows[i].d, rows[i].s, i);
			chk("wresp", rr, rows[i].r);
			rd(rows[i].a, i);
			chk("rdata", rq, rows[i].q);
			chk("rresp", rr, rows[i].r);
		end
		// Mid-run reset returns pads and configuration to idle
		rst_b <= 1'b0;
		tick(3);
		chk("oe_b", pad_oe_b, 6'h3f);
		rst_b <= 1'b1;
		tick(3);
		rd(8'h10);
		chk("line0", rq, 32'h0);
		rd(8'h54);
		chk("cell5", rq, 32'h0);
		// Lines fed by pin, first cells of two rows and a column channel
		wr(8'h28, 32'h11); wr(8'h2c, 32'he); wr(8'h34, 32'h17); wr(8'h3c, 32'h6);
		ded <= 6'h0a;
		tick(8);
		chk("glb", glb, 4'ha);
		wr(8'h00, 32'hf);
		tie <= 4'hf;
		for (int i = 0; i < 2; i++)
		begin
			v = i ? 4'h5 : 4'ha;
			ded <= {1'b0, v[0], 4'h0};
			lc <= {2'h0, v[3], 5'h0, v[1], 3'h0};
			col <= {2'h0, v[2], 5'h0};
			tick(8);
			chk("glb", glb, v);
			rd(8'h04);
			chk("lines", rq & 32'hffff,
				{16'h0, v, v[3], 1'b0, v[2], 1'b0, v[1], v[0], 6'h0});
		end
		wr(8'h00, 32'h0);
		tie <= 4'h0;
		// Output cells from row and column multiplexers, bidir on bus OE
		wr(8'h40, 32'h2_0002); wr(8'h50, 32'h4_0002); wr(8'h54, 32'h4_0002);
		wr(8'h18, 32'hd); wr(8'h44, 32'h1003);
		for (int i = 0; i < 2; i++)
		begin
			row <= i ? 16'h0100 : 16'h0002;
			col <= i ? 8'h04 : 8'h08;
			ded <= i ? 6'h08 : 6'h00;
			tick(8);
			chk("pad", pad_out & 6'h31,
				i ? 6'h11 : 6'h20);
			chk("oe_b", pad_oe_b, i ? 6'h0c : 6'h0e);
		end
		chip_oe_b <= 1'b0;
		tick(5);
		chk("oe_b", pad_oe_b, 6'h3f);
		chip_oe_b <= 1'b1;
		wr(8'h44, 32'h4003);
		oe <= 6'h02; ded <= 6'h00;
		tick(8);
		chk("oe_b", pad_oe_b[1], 1'b0);
		// Input cells drive two row and two column channels
		wr(8'h48, 32'h1); wr(8'h50, 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			pad_in <= i ? 6'h14 : 6'h00;
			tick(6);
			chk("row_drv", row_drv, i ? 16'h0030 : 16'h0);
			chk("col_drv", col_drv, i ? 8'h03 : 8'h00);
		end
		// Input register on a clock pin, chip reset, logic cell enable
		wr(8'h4c, 32'h8009);
		pad_in <= 6'h08;
		pulse();
		rd(8'h04);
		chk("q", rq[19], 1'b1);
		chip_rst_b <= 1'b0;
		tick(4);
		pulse();
		chip_rst_b <= 1'b1;
		tick(4);
		rd(8'h04);
		chk("q", rq[19], 1'b0);
		wr(8'h4c, 32'h8609);
		pulse();
		rd(8'h04);
		chk("q", rq[19], 1'b0);
		ce <= 6'h08;
		pulse();
		rd(8'h04);
		chk("q", rq[19], 1'b1);
		// Output register on bus clock line 6, cleared from line 10
		wr(8'h38, 32'h2);
		wr(8'h4c, 32'h1_0032);
		row <= 16'h0;
		lc <= 12'h100;
		tick(6);
		chk("pad", pad_out[3], 1'b0);
		lc <= 12'h0;
		row <= 16'h0008;
		ded <= 6'h10;
		tick(4);
		ded <= 6'h00;
		tick(4);
		chk("pad", pad_out[3], 1'b1);
		close_out();
	end
endmodule : iocn_top_tb
